/* common/pfr_map.svh */
// Purpose: offsets, field positions, reset values for the fault reporting block
// Assumes: word-indexed register port, 32-bit data
// Notes: included by bare name
`ifndef PFR_MAP_SVH
`define PFR_MAP_SVH
`define PFR_ADDR_CTRL0 4'h0
`define PFR_ADDR_CTRL4 4'h1
`define PFR_ADDR_FADDR 4'h2
`define PFR_ADDR_ECODE 4'h3
`define PFR_ADDR_CSSAVE 4'h4
`define PFR_ADDR_IPSAVE 4'h5
`define PFR_ADDR_VECTOR 4'h6
`define PFR_ADDR_STATUS 4'h7
`define PFR_ADDR_MASK 4'h8
`define PFR_CR0_PG 31
`define PFR_CR0_WP 16
`define PFR_CR4_PSE 4
`define PFR_CR4_PAE 5
`define PFR_EC_P 0
`define PFR_EC_WR 1
`define PFR_EC_US 2
`define PFR_EC_RESERVED_BIT_VIOLATION 3
`define PFR_RST_WORD 32'h0000_0000
`define PFR_VEC_GP 8'h0d
`define PFR_VEC_PF 8'h0e
`define PFR_PDE_ACCESS 5
`define PFR_ST_GP 0
`define PFR_ST_PF 1
`endif

/* common/pfr_pkg.sv */
// Purpose: types for the fault reporting block
// Assumes: nothing
// Notes: constants live in pfr_map.svh
package pfr_pkg;
  typedef enum logic [1:0] {
    PFR_IDLE = 2'b00,
    PFR_LOAD = 2'b01,
    PFR_RAISE = 2'b11
  } pfr_state_t;
  typedef enum logic [1:0] {
    PFR_SRC_OPERAND = 2'h0,
    PFR_SRC_GATE = 2'h1,
    PFR_SRC_TSS = 2'h2,
    PFR_SRC_VECTOR = 2'h3
  } pfr_sel_src_t;
endpackage

/* dv/pfr_fault_chk_sva.sv */
// Purpose: port assertions for the fault unit
// Assumes: one clock, sync reset
// Notes: bound below
`timescale 1ns/1ps
module pfr_fault_chk
(
  input wire logic clk,
  input wire logic rst,
  input wire logic gpReq,
  input wire logic gpDescLoad,
  input wire logic inTaskSwitch,
  input wire logic pastCommit,
  input wire logic pfReq,
  input wire logic entryPresent,
  input wire logic isWrite,
  input wire logic userMode,
  input wire logic [31:0] curIp,
  input wire logic commitState,
  input wire logic loadNewTask,
  input wire logic pdeAccessSet,
  input wire logic excValid,
  input wire logic [7:0] excVector,
  input wire logic [31:0] excCode,
  input wire logic [31:0] savedIp
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  logic pfV;
  logic gpV;
  assign pfV = excValid && excVector == 8'h0e;
  assign gpV = excValid && excVector == 8'h0d;
  pf_hi_zero_a:
    assert property (pfV |-> excCode[31:4] == 28'h0) else $error("pf code high bits set");
  pf_p_bit_a:
    assert property (pfV |-> excCode[0] == $past(entryPresent)) else $error("pf present bit");
  pf_rw_us_a:
    assert property (pfV |-> excCode[2:1] == {$past(userMode), $past(isWrite)})
    else $error("pf mode bits wrong");
  gp_zero_a:
    assert property (gpV && $past(gpReq) && !$past(gpDescLoad) && !$past(loadNewTask, 2)
      |-> excCode == 32'h0) else $error("gp code not zero");
  gp_ip_a:
    assert property (gpV && $past(gpReq) && !$past(loadNewTask, 2)
      |-> savedIp == $past(curIp)) else $error("gp ip");
  gp_hold_a:
    assert property (gpReq && !inTaskSwitch |-> !commitState) else $error("gp commits");
  gp_early_a:
    assert property (gpReq && inTaskSwitch && !pastCommit && !loadNewTask |=> !loadNewTask)
    else $error("early gp loads task");
  gp_defer_a:
    assert property (gpReq && inTaskSwitch && pastCommit && !pfReq && $past(commitState)
      && !loadNewTask |=> loadNewTask) else $error("late gp skips load");
  gp_wait_a:
    assert property (loadNewTask |-> !excValid) else $error("gp raised before load");
  pde_flag_a:
    assert property (pdeAccessSet |-> pfV && excCode[0]) else $error("pde flag stray");
  pf_c: cover property (pfV && pdeAccessSet);
  gp_c: cover property (gpV && excCode != 32'h0);
  defer_c: cover property (loadNewTask ##1 !loadNewTask);
endmodule
bind pfr_fault_unit pfr_fault_chk chk_u (.*);

/* dv/protection_and_page_fault_reporting_tb.sv */
// Purpose: self-checking bench for the fault unit
// Assumes: reads answer one cycle later
// Notes: seeded random walk attributes
`timescale 1ns/1ps
module protection_and_page_fault_reporting_tb;
  logic clk = '0;
  logic rst = '1;
  logic regWr = '0, regRd = '0, gpReq = '0, gpDescLoad = '0, inTaskSwitch = '0;
  logic pastCommit = '0, newTaskLoaded = '0, pfReq = '0, entryPresent = '0, pageUser = '0;
  logic pageWritable = '0, rsvdSet = '0, isWrite = '0, userMode = '0;
  logic irq, commitState, loadNewTask, pdeAccessSet, excValid;
  logic [1:0] gpSelSrc = '0;
  logic [3:0] regAddr = '0;
  logic [7:0] vectorNum = '0, excVector;
  logic [15:0] operandSel = '0, gateSel = '0, tssSel = '0, curCs = '0, newTaskCs = '0, savedCs;
  logic [31:0] regWrData = '0, linearAddr = '0, curIp = '0, newTaskIp = '0, regRdData;
  logic [31:0] excCode, savedIp;
  int errCount = 0, comparisons = 0;
  always #2 clk = ~clk;
  pfr_fault_unit dut_u (.*);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk("regRdData", exp, regRdData);
  endtask
  // a: userMode, isWrite, rsvdSet, pageWritable, pageUser, entryPresent
  task automatic pf(input logic [5:0] a, input logic pg, input logic big, input logic wp);
    logic f;
    logic p;
    a[3] = a[3] & a[0];
    p = a[0] && ((a[5] && !a[1]) || (a[4] && !a[2] && (a[5] || (wp && a[1]))));
    f = pg && (!a[0] || a[3] || p);
    @(posedge clk);
    {userMode, isWrite, rsvdSet, pageWritable, pageUser, entryPresent} <= a;
    linearAddr <= $urandom;
    curIp <= $urandom;
    curCs <= 16'($urandom);
    pfReq <= 1'b1;
    #1 chk("commitState", !f, commitState);
    @(posedge clk);
    pfReq <= 1'b0;
    #1 chk("excValid", f, excValid);
    if (f)
    begin
      chk("excVector", 8'h0e, excVector);
      chk("excCode", {28'h0, a[3] & big, a[5], a[4], a[0]}, excCode);
      chk("savedIp", newTaskLoaded ? newTaskIp : curIp, savedIp);
      chk("savedCs", {16'h0, newTaskLoaded ? newTaskCs : curCs}, {16'h0, savedCs});
      chk("pdeAccessSet", p, pdeAccessSet);
      rd(4'h2, linearAddr);
    end
  endtask
  task automatic gp(input logic [1:0] s, input logic dl, input logic ts, input logic pc);
    logic [31:0] c;
    logic [31:0] ip;
    logic [15:0] cs;
    logic [15:0] o;
    logic [15:0] g;
    logic [15:0] t;
    logic [7:0] v;
    int n;
    ip = $urandom;
    cs = 16'($urandom);
    o = 16'($urandom);
    g = 16'($urandom);
    t = 16'($urandom);
    v = 8'($urandom);
    case (s)
      2'h0: c = {16'h0, o};
      2'h1: c = {16'h0, g};
      2'h2: c = {16'h0, t};
      default: c = {21'h0, v, 3'b010};
    endcase
    if (!dl)
      c = '0;
    @(posedge clk);
    {gpReq, gpDescLoad, gpSelSrc, inTaskSwitch, pastCommit} <= {1'b1, dl, s, ts, pc};
    {operandSel, gateSel, tssSel, vectorNum} <= {o, g, t, v};
    curIp <= ip;
    curCs <= cs;
    #1 chk("commitState", 1'b0, commitState);
    @(posedge clk);
    gpReq <= 1'b0;
    curIp <= ~ip;
    curCs <= ~cs;
    if (ts && pc)
    begin
      #1 chk("loadNewTask", 1'b1, loadNewTask);
      repeat (3) @(posedge clk);
      newTaskLoaded <= 1'b1;
      #1 chk("excValid", 1'b0, excValid);
      for (n = 0; n < 10 && excValid !== 1'b1; n++)
      begin
        @(posedge clk);
        #1;
      end
      newTaskLoaded <= 1'b0;
      if (excValid !== 1'b1)
      begin
        chk("excValid", 1'b1, excValid);
        print_verdict();
      end
    end
    else
      #1;
    chk("excValid", 1'b1, excValid);
    chk("excVector", 8'h0d, excVector);
    chk("excCode", c, excCode);
    chk("savedIp", ip, savedIp);
    chk("savedCs", {16'h0, cs}, {16'h0, savedCs});
    chk("loadNewTask", 1'b0, loadNewTask);
  endtask
  initial
  begin
    int i;
    int j;
    void'($urandom(20));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 9; i++)
      rd(i[3:0], 32'h0);
    wr(4'hf, 32'hffff_ffff);
    rd(4'hf, 32'h0);
    $display("register reset test done");
    pf(6'h0, 1'b0, 1'b0, 1'b0);
    for (j = 0; j < 2; j++)
    begin
      wr(4'h0, j ? 32'h8000_0000 : 32'h8001_0000);
      wr(4'h1, j ? 32'h30 : 32'h0);
      pf(6'h19, 1'b1, j[0], !j[0]);
      pf(6'h13, 1'b1, j[0], !j[0]);
      for (i = 0; i < 40; i++)
        pf(6'($urandom), 1'b1, j[0], !j[0]);
    end
    $display("page fault test done");
    wr(4'h7, 32'h3);
    pf(6'h0, 1'b1, 1'b1, 1'b0);
    #1 chk("irq", 1'b0, irq);
    rd(4'h7, 32'h2);
    wr(4'h8, 32'h2);
    #1 chk("irq", 1'b1, irq);
    wr(4'h7, 32'h2);
    #1 chk("irq", 1'b0, irq);
    $display("interrupt test done");
    for (i = 0; i < 8; i++)
      gp(i[1:0], i[2], 1'b0, 1'b0);
    gp(2'h2, 1'b1, 1'b1, 1'b0);
    gp(2'h0, 1'b1, 1'b1, 1'b1);
    gp(2'h3, 1'b0, 1'b1, 1'b1);
    $display("protection fault test done");
    @(posedge clk);
    newTaskCs <= 16'($urandom);
    newTaskIp <= $urandom;
    newTaskLoaded <= 1'b1;
    pf(6'h0, 1'b1, 1'b1, 1'b0);
    $display("task switch page fault test done");
    print_verdict();
  end
endmodule

/* hdl/pfr_fault_unit.sv */
// Purpose: protection and page fault reporting toward exception dispatch
// Assumes: fault requests are one-cycle pulses on clk; register port strobes one cycle
// Notes: loadNewTask holds high to ask the core to load new task state before raising
// Summary of operation
// - protection fault pushes selector or vector code on descriptor loads, else zero
// - selector may come from operand, gate, task state segment, or vector
// - saved segment and pointer of a protection fault name the faulting instruction
// - protection fault blocks state update so the task can restart
// - protection fault before task-switch commit changes no state
// - after commit, load new task state unchecked, then raise the fault
// - page faults only with paging enabled; not-present entry is one cause
// - user access to supervisor page or user write to read-only page faults
// - with write protect, supervisor write to read-only user page faults
// - a reserved directory bit set to one raises a page fault
// - code bit 0 is zero for not-present, one for protection or reserved
// - code bit 1 is one for a write, zero for a read
// - code bit 2 is one in user mode, zero in supervisor mode
// - code bit 3 flags reserved bits when large pages or extension enabled
// - every page fault taken while the sequencer is idle loads the full linear address into fault address register
// - protection-caused page fault sets the directory entry access flag
// - page fault saved pointer names faulting instruction, or new task start
// - page fault blocks state update so the instruction can resume
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "pfr_map.svh"
module pfr_fault_unit
  import pfr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  output logic irq,
  input wire logic gpReq,
  input wire logic gpDescLoad,
  input wire logic [1:0] gpSelSrc,
  input wire logic [15:0] operandSel,
  input wire logic [15:0] gateSel,
  input wire logic [15:0] tssSel,
  input wire logic [7:0] vectorNum,
  input wire logic inTaskSwitch,
  input wire logic pastCommit,
  input wire logic newTaskLoaded,
  input wire logic pfReq,
  input wire logic entryPresent,
  input wire logic pageUser,
  input wire logic pageWritable,
  input wire logic rsvdSet,
  input wire logic isWrite,
  input wire logic userMode,
  input wire logic [31:0] linearAddr,
  input wire logic [15:0] curCs,
  input wire logic [31:0] curIp,
  input wire logic [15:0] newTaskCs,
  input wire logic [31:0] newTaskIp,
  output logic commitState,
  output logic loadNewTask,
  output logic pdeAccessSet,
  output logic excValid,
  output logic [7:0] excVector,
  output logic [31:0] excCode,
  output logic [15:0] savedCs,
  output logic [31:0] savedIp
);
  logic [31:0] ctrlZero_r;
  logic [31:0] ctrlFour_r;
  logic [31:0] faultAddr_r;
  logic [31:0] errCode_r;
  logic [15:0] csSave_r;
  logic [31:0] ipSave_r;
  logic [7:0] vector_r;
  logic [1:0] status_r;
  logic [1:0] mask_r;
  logic [31:0] rdData_r;
  logic excValid_r;
  logic pdeAccess_r;
  logic [31:0] pendCode_r;
  logic [15:0] pendCs_r;
  logic [31:0] pendIp_r;
  pfr_state_t state_r;
  pfr_state_t state_nxt;
  logic [31:0] gpCode;
  logic [31:0] pfCode;
  logic pfFault;
  logic pfProt;
  logic pfTake;
  logic gpTake;
  logic gpDefer;
  logic gpNow;
  logic [1:0] evSet;

  // write strobe decode shared by the fault address and status register processes
  function automatic logic wrHit(input logic wr, input logic [3:0] a, input logic [3:0] want);
    wrHit = wr && (a == want);
  endfunction

  pfr_gp_code uGp (
    .descLoad(gpDescLoad),
    .selSrc(gpSelSrc),
    .operandSel(operandSel),
    .gateSel(gateSel),
    .tssSel(tssSel),
    .vectorNum(vectorNum),
    .code(gpCode)
  );

  pfr_pf_code uPf (
    .pagingOn(ctrlZero_r[`PFR_CR0_PG]),
    .wpOn(ctrlZero_r[`PFR_CR0_WP]),
    .pseOn(ctrlFour_r[`PFR_CR4_PSE]),
    .paeOn(ctrlFour_r[`PFR_CR4_PAE]),
    .entryPresent(entryPresent),
    .pageUser(pageUser),
    .pageWritable(pageWritable),
    .rsvdSet(rsvdSet),
    .isWrite(isWrite),
    .userMode(userMode),
    .fault(pfFault),
    .protViol(pfProt),
    .code(pfCode)
  );

  // page fault has priority; a protection fault in the same cycle is dropped
  always_comb
  begin
    pfTake = pfReq && pfFault && (state_r == PFR_IDLE);
    gpTake = gpReq && !pfTake && (state_r == PFR_IDLE);
    gpDefer = gpTake && inTaskSwitch && pastCommit;
    gpNow = gpTake && !gpDefer;
    evSet = {pfTake, gpNow};
    if (state_r == PFR_RAISE)
    begin
      evSet[`PFR_ST_GP] = 1'b1;
    end
  end

  // idle, wait for the new task load, then raise for one cycle
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      PFR_IDLE:
      begin
        if (gpDefer)
        begin
          state_nxt = PFR_LOAD;
        end
      end
      PFR_LOAD:
      begin
        if (newTaskLoaded)
        begin
          state_nxt = PFR_RAISE;
        end
      end
      PFR_RAISE: state_nxt = PFR_IDLE;
      default: state_nxt = PFR_IDLE;
    endcase
  end

  // deferred protection fault sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= PFR_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // hold the code and frame of a deferred protection fault
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pendCode_r <= `PFR_RST_WORD;
      pendCs_r <= 16'h0000;
      pendIp_r <= `PFR_RST_WORD;
    end
    else if (gpDefer)
    begin
      pendCode_r <= gpCode;
      pendCs_r <= curCs;
      pendIp_r <= curIp;
    end
  end

  // exception frame toward dispatch
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      excValid_r <= 1'b0;
      errCode_r <= `PFR_RST_WORD;
      csSave_r <= 16'h0000;
      ipSave_r <= `PFR_RST_WORD;
      vector_r <= 8'h00;
    end
    else
    begin
      excValid_r <= pfTake || gpNow || (state_r == PFR_RAISE);
      if (pfTake)
      begin
        errCode_r <= pfCode;
        vector_r <= `PFR_VEC_PF;
        csSave_r <= (inTaskSwitch && newTaskLoaded) ? newTaskCs : curCs;
        ipSave_r <= (inTaskSwitch && newTaskLoaded) ? newTaskIp : curIp;
      end
      else if (gpNow)
      begin
        errCode_r <= gpCode;
        vector_r <= `PFR_VEC_GP;
        csSave_r <= curCs;
        ipSave_r <= curIp;
      end
      else if (state_r == PFR_RAISE)
      begin
        errCode_r <= pendCode_r;
        vector_r <= `PFR_VEC_GP;
        csSave_r <= pendCs_r;
        ipSave_r <= pendIp_r;
      end
    end
  end

  // fault address is also writable so a handler can clear it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      faultAddr_r <= `PFR_RST_WORD;
    end
    else if (pfTake)
    begin
      faultAddr_r <= linearAddr;
    end
    else if (wrHit(regWr, regAddr, `PFR_ADDR_FADDR))
    begin
      faultAddr_r <= regWrData;
    end
  end

  // access flag pulse goes out with the frame of a protection-caused page fault
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pdeAccess_r <= 1'b0;
    end
    else
    begin
      pdeAccess_r <= pfTake && pfProt;
    end
  end

  // control words are plain storage; only the flag bits are decoded
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrlZero_r <= `PFR_RST_WORD;
      ctrlFour_r <= `PFR_RST_WORD;
      mask_r <= 2'h0;
    end
    else if (regWr)
    begin
      case (regAddr)
        `PFR_ADDR_CTRL0: ctrlZero_r <= regWrData;
        `PFR_ADDR_CTRL4: ctrlFour_r <= regWrData;
        `PFR_ADDR_MASK: mask_r <= regWrData[1:0];
        default: mask_r <= mask_r;
      endcase
    end
  end

  // sticky events, write one to clear, a new event wins over the clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_r <= 2'h0;
    end
    else if (wrHit(regWr, regAddr, `PFR_ADDR_STATUS))
    begin
      status_r <= (status_r & ~regWrData[1:0]) | evSet;
    end
    else
    begin
      status_r <= status_r | evSet;
    end
  end

  // read data stand for one cycle only, zero otherwise
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdData_r <= `PFR_RST_WORD;
    end
    else if (regRd)
    begin
      case (regAddr)
        `PFR_ADDR_CTRL0: rdData_r <= ctrlZero_r;
        `PFR_ADDR_CTRL4: rdData_r <= ctrlFour_r;
        `PFR_ADDR_FADDR: rdData_r <= faultAddr_r;
        `PFR_ADDR_ECODE: rdData_r <= errCode_r;
        `PFR_ADDR_CSSAVE: rdData_r <= {16'h0000, csSave_r};
        `PFR_ADDR_IPSAVE: rdData_r <= ipSave_r;
        `PFR_ADDR_VECTOR: rdData_r <= {24'h000000, vector_r};
        `PFR_ADDR_STATUS: rdData_r <= {30'h0, status_r};
        `PFR_ADDR_MASK: rdData_r <= {30'h0, mask_r};
        default: rdData_r <= `PFR_RST_WORD;
      endcase
    end
    else
    begin
      rdData_r <= `PFR_RST_WORD;
    end
  end

  // commit is withheld for any fault taken, so the instruction does not retire
  always_comb
  begin
    commitState = !(pfTake || gpTake) && (state_r == PFR_IDLE);
    loadNewTask = (state_r == PFR_LOAD);
  end

  assign regRdData = rdData_r;
  assign irq = |(status_r & mask_r);
  assign pdeAccessSet = pdeAccess_r;
  assign excValid = excValid_r;
  assign excVector = vector_r;
  assign excCode = errCode_r;
  assign savedCs = csSave_r;
  assign savedIp = ipSave_r;
endmodule

/* hdl/pfr_gp_code.sv */
// Purpose: general protection error code formation
// Assumes: selector source picked by the checker that flagged the fault
// Notes: purely combinational
`timescale 1ns/1ps
module pfr_gp_code
  import pfr_pkg::*;
(
  input wire logic descLoad,
  input wire logic [1:0] selSrc,
  input wire logic [15:0] operandSel,
  input wire logic [15:0] gateSel,
  input wire logic [15:0] tssSel,
  input wire logic [7:0] vectorNum,
  output logic [31:0] code
);
  always_comb
  begin
    code = 32'h0000_0000;
    if (descLoad)
    begin
      case (pfr_sel_src_t'(selSrc))
        PFR_SRC_OPERAND: code = {16'h0000, operandSel};
        PFR_SRC_GATE: code = {16'h0000, gateSel};
        PFR_SRC_TSS: code = {16'h0000, tssSel};
        PFR_SRC_VECTOR: code = {21'h0, vectorNum, 3'h2};
        default: code = 32'h0000_0000;
      endcase
    end
  end
endmodule

/* hdl/pfr_pf_code.sv */
// Purpose: page fault detection and four-bit error code
// Assumes: translation walk supplies entry attributes
// Notes: purely combinational
`timescale 1ns/1ps
`include "pfr_map.svh"
module pfr_pf_code
  import pfr_pkg::*;
(
  input wire logic pagingOn,
  input wire logic wpOn,
  input wire logic pseOn,
  input wire logic paeOn,
  input wire logic entryPresent,
  input wire logic pageUser,
  input wire logic pageWritable,
  input wire logic rsvdSet,
  input wire logic isWrite,
  input wire logic userMode,
  output logic fault,
  output logic protViol,
  output logic [31:0] code
);
  logic privViol;
  logic wrViol;
  logic rsvdViol;
  always_comb
  begin
    privViol = userMode && !pageUser;
    wrViol = isWrite && !pageWritable && (userMode || (wpOn && pageUser));
    rsvdViol = rsvdSet;
    protViol = entryPresent && (privViol || wrViol);
    fault = pagingOn && (!entryPresent || privViol || wrViol || rsvdViol);
    code = `PFR_RST_WORD;
    code[`PFR_EC_P] = entryPresent && (privViol || wrViol || rsvdViol);
    code[`PFR_EC_WR] = isWrite;
    code[`PFR_EC_US] = userMode;
    code[`PFR_EC_RESERVED_BIT_VIOLATION] = rsvdViol && (pseOn || paeOn);
  end
endmodule
